// ### hw/tgr_defs.vh
`ifndef TGR_DEFS_VH
`define TGR_DEFS_VH
// command codes of this register group
`define TGR_CMD_SCALE 8'hD9
`define TGR_CMD_OFFSET 8'hDA
`define TGR_CMD_TCCFG 8'hDC
`define TGR_CMD_GAPT 8'hDD
`define TGR_CMD_GAPC 8'hDE
// reset values
`define TGR_RST_SCALE 16'hBA00
`define TGR_RST_OFFSET 16'h0000
`define TGR_RST_TCCFG 8'h27
`define TGR_RST_GAPT 16'h1010
`define TGR_RST_GAPC 16'h0808
`define TGR_RST_GAP 8'h10
// linear-11 fields
`define TGR_L11_EXP 15:11
`define TGR_L11_EXP_SIGN 15
`define TGR_L11_MAN 10:0
`define TGR_L11_MAN_SIGN 10
// correction byte fields
`define TGR_TC_SRC 7
`define TGR_TC_COEF 6:0
// gap time fields
`define TGR_GAPT_HL 15:8
`define TGR_GAPT_LH 7:0
// gap control fields
`define TGR_GAPC_FRZ_HL 15
`define TGR_GAPC_FRZ_LH 7
`define TGR_GAPC_MIN_HL 14:8
`define TGR_GAPC_MIN_LH 6:0
// supported gap range in ns, 10-bit two's complement
`define TGR_GAP_LO 10'h3F1
`define TGR_GAP_HI 10'h03C
// fixed-point constants, Q8 fraction
`define TGR_QFRAC 8
`define TGR_TREF_Q8 32'h00001900
`define TGR_TC_DIV 64'h0000000000271000
`endif

// ### hw/tgr_page_regs.v
`include "tgr_defs.vh"

module tgr_page_regs (
	input wire mclk,
	input wire reset,
	input wire wr_en,
	input wire [7:0] wr_code,
	input wire [15:0] wr_data,
	input wire [7:0] adapt_hl,
	input wire [7:0] adapt_lh,
	input wire [7:0] gap_upper,
	output reg [15:0] scale,
	output reg [15:0] offset,
	output reg [7:0] tccfg,
	output reg [15:0] gapt,
	output reg [15:0] gapc,
	output reg [7:0] gap_hl,
	output reg [7:0] gap_lh,
	output reg ovl_hl,
	output reg ovl_lh
);

	wire [7:0] next_gap_hl;
	wire [7:0] next_gap_lh;

	// limit a gap between min field, upper limit and supported range
	function [7:0] gclamp;
		input [7:0] v;
		input [6:0] mfield;
		input [7:0] mx;
		reg signed [9:0] sv;
		reg signed [9:0] lo;
		reg signed [9:0] hi;
		begin
			sv = $signed({{2{v[7]}}, v});
			lo = $signed({2'b00, mfield, 1'b0}); // 2 ns steps
			if (lo < $signed(`TGR_GAP_LO))
				lo = $signed(`TGR_GAP_LO);
			hi = $signed({{2{mx[7]}}, mx});
			if (hi > $signed(`TGR_GAP_HI))
				hi = $signed(`TGR_GAP_HI);
			if (hi < $signed(`TGR_GAP_LO))
				hi = $signed(`TGR_GAP_LO);
			if (sv < lo)
				sv = lo;
			if (sv > hi)
				sv = hi;
			gclamp = sv[7:0];
		end
	endfunction

	// adaptive follows the engine; frozen holds, or takes a written value
	assign next_gap_hl = !gapc[`TGR_GAPC_FRZ_HL] ?
		gclamp(adapt_hl, gapc[`TGR_GAPC_MIN_HL], gap_upper) :
		(wr_en && wr_code == `TGR_CMD_GAPT) ?
		gclamp(wr_data[`TGR_GAPT_HL], gapc[`TGR_GAPC_MIN_HL], gap_upper) :
		gap_hl;
	assign next_gap_lh = !gapc[`TGR_GAPC_FRZ_LH] ?
		gclamp(adapt_lh, gapc[`TGR_GAPC_MIN_LH], gap_upper) :
		(wr_en && wr_code == `TGR_CMD_GAPT) ?
		gclamp(wr_data[`TGR_GAPT_LH], gapc[`TGR_GAPC_MIN_LH], gap_upper) :
		gap_lh;

	// register storage and applied gaps
	always @(posedge mclk)
	begin
		if (reset)
		begin
			scale <= `TGR_RST_SCALE;
			offset <= `TGR_RST_OFFSET;
			tccfg <= `TGR_RST_TCCFG;
			gapt <= `TGR_RST_GAPT;
			gapc <= `TGR_RST_GAPC;
			gap_hl <= `TGR_RST_GAP;
			gap_lh <= `TGR_RST_GAP;
			ovl_hl <= 1'b0;
			ovl_lh <= 1'b0;
		end
		else
		begin
			if (wr_en)
			begin
				case (wr_code)
				`TGR_CMD_SCALE: scale <= wr_data;
				`TGR_CMD_OFFSET: offset <= wr_data;
				`TGR_CMD_TCCFG: tccfg <= wr_data[7:0];
				`TGR_CMD_GAPT: gapt <= wr_data;
				`TGR_CMD_GAPC: gapc <= wr_data;
				default: ;
				endcase
			end
			gap_hl <= next_gap_hl;
			gap_lh <= next_gap_lh;
			ovl_hl <= next_gap_hl[7]; // negative gap means overlap
			ovl_lh <= next_gap_lh[7];
		end
	end

endmodule // tgr_page_regs

// ### hw/tgr_regs.v
// Behaviour
// - scale register: 16-bit linear-11, per page, resets to 1.0, range 0.1-10.
// - reported external temperature is raw divided by scale plus offset.
// - linear-11 value is signed mantissa in low bits times two^signed exponent.
// - correction byte bit 7 picks internal sensor (0) or external pin (1).
// - correction bits 6:0 in 100 ppm/C steps, byte resets to 27h.
// - sense resistance equals gain times one plus coefficient times T-25.
// - gap times: upper byte high-to-low, lower byte low-to-high, signed ns.
// - positive gap gives non-overlap, negative gives overlap of on-times.
// - frozen mode applies written gaps, limited by minimum and maximum gap.
// - switching to frozen holds the last gap that was in use.
// - gap times reset to 16 ns each; supported range -15 to 60 ns.
// - gap control selects adaptive mode and sets adaptive minimum gap.
// - bits 15 and 7 freeze each gap; 14:8, 6:0 minimum in 2 ns.
// - gap control resets to adaptive with 16 ns minimum on both sides.
// - every register is kept per page and obeys write protection.
`include "tgr_defs.vh"

module tgr_regs #(
	parameter NUM_PAGES = 2,
	parameter PAGE_W = 1
) (
	input wire mclk,
	input wire reset,
	input wire cmd_valid,
	input wire cmd_write,
	input wire [PAGE_W-1:0] cmd_page,
	input wire [7:0] cmd_code,
	input wire [15:0] cmd_wdata,
	input wire write_protect,
	output reg rsp_valid,
	output reg [15:0] rsp_data,
	output reg rsp_error,
	input wire [NUM_PAGES*16-1:0] ext_temp_raw,
	input wire [15:0] int_temp_raw,
	input wire [NUM_PAGES*16-1:0] current_sense_gain,
	input wire [NUM_PAGES*8-1:0] adaptive_gap_hl,
	input wire [NUM_PAGES*8-1:0] adaptive_gap_lh,
	input wire [NUM_PAGES*8-1:0] switch_gap_upper_limit,
	output reg [NUM_PAGES*16-1:0] ext_temp_report,
	output reg [NUM_PAGES*32-1:0] sense_resistance,
	output wire [NUM_PAGES*8-1:0] gap_hl_ns,
	output wire [NUM_PAGES*8-1:0] gap_lh_ns,
	output wire [NUM_PAGES-1:0] gap_overlap_hl,
	output wire [NUM_PAGES-1:0] gap_overlap_lh
);

	wire [NUM_PAGES*16-1:0] pg_scale;
	wire [NUM_PAGES*16-1:0] pg_offset;
	wire [NUM_PAGES*8-1:0] pg_tccfg;
	wire [NUM_PAGES*16-1:0] pg_gapt;
	wire [NUM_PAGES*16-1:0] pg_gapc;
	wire code_ok;
	wire page_ok;
	wire wr_ok;
	reg [15:0] next_rd;
	wire [NUM_PAGES*16-1:0] rep_all;
	wire [NUM_PAGES*32-1:0] res_all;
	wire refuse;
	wire rd_take;

	// decode a linear-11 word into signed Q8 fixed point
	function signed [31:0] lin11_q8;
		input [15:0] w;
		reg signed [31:0] m;
		reg [4:0] e;
		begin
			m = $signed({{21{w[`TGR_L11_MAN_SIGN]}}, w[`TGR_L11_MAN]});
			m = m <<< `TGR_QFRAC;
			e = w[`TGR_L11_EXP];
			if (w[`TGR_L11_EXP_SIGN])
				m = m >>> (5'd0 - e); // negative exponent
			else
				m = m <<< e;
			lin11_q8 = m;
		end
	endfunction

	// command acceptance
	assign code_ok = (cmd_code == `TGR_CMD_SCALE) ||
		(cmd_code == `TGR_CMD_OFFSET) || (cmd_code == `TGR_CMD_TCCFG) ||
		(cmd_code == `TGR_CMD_GAPT) || (cmd_code == `TGR_CMD_GAPC);

	// pages past NUM_PAGES keep nothing and answer with an error
	assign page_ok = ({1'b0, cmd_page} < NUM_PAGES);
	assign wr_ok = cmd_valid && cmd_write && code_ok && page_ok &&
		!write_protect;

	// protection refuses writes only, reads stay allowed
	assign refuse = !code_ok || !page_ok ||
		(cmd_write && write_protect);

	// reads answer with data, writes with zero
	assign rd_take = cmd_valid && !cmd_write;

	genvar p;
	generate
		for (p = 0; p < NUM_PAGES; p = p + 1)
		begin : g_page
			wire [7:0] gh;
			wire [7:0] gl;
			wire signed [31:0] scale_q8;
			wire signed [31:0] off_q8;
			wire signed [31:0] raw_q8;
			wire signed [31:0] rep_q8;
			wire signed [31:0] t_q8;
			wire signed [31:0] int_q8;
			wire signed [31:0] dt_q8;
			wire signed [63:0] gain_q8;
			wire signed [63:0] corr;
			wire signed [63:0] res_q8;

			// one register set per page
			tgr_page_regs u_regs (
				.mclk(mclk),
				.reset(reset),
				.wr_en(wr_ok && cmd_page == p),
				.wr_code(cmd_code),
				.wr_data(cmd_wdata),
				.adapt_hl(adaptive_gap_hl[p*8 +: 8]),
				.adapt_lh(adaptive_gap_lh[p*8 +: 8]),
				.gap_upper(switch_gap_upper_limit[p*8 +: 8]),
				.scale(pg_scale[p*16 +: 16]),
				.offset(pg_offset[p*16 +: 16]),
				.tccfg(pg_tccfg[p*8 +: 8]),
				.gapt(pg_gapt[p*16 +: 16]),
				.gapc(pg_gapc[p*16 +: 16]),
				.gap_hl(gh),
				.gap_lh(gl),
				.ovl_hl(gap_overlap_hl[p]),
				.ovl_lh(gap_overlap_lh[p])
			);
			assign gap_hl_ns[p*8 +: 8] = gh;
			assign gap_lh_ns[p*8 +: 8] = gl;

			// calibrated external temperature, Q8 degrees
			assign scale_q8 = lin11_q8(pg_scale[p*16 +: 16]);
			assign off_q8 = lin11_q8(pg_offset[p*16 +: 16]);
			assign raw_q8 = $signed({{16{ext_temp_raw[p*16+15]}},
				ext_temp_raw[p*16 +: 16]});
			assign rep_q8 = ((scale_q8 > 0) ?
				((raw_q8 <<< `TGR_QFRAC) / scale_q8) : raw_q8) +
				off_q8;

			// sense temperature source and resistance correction
			assign int_q8 = $signed({{16{int_temp_raw[15]}},
				int_temp_raw});
			assign t_q8 = pg_tccfg[p*8+`TGR_TC_SRC] ? rep_q8 :
				int_q8;
			assign dt_q8 = t_q8 - $signed(`TGR_TREF_Q8);
			assign gain_q8 = lin11_q8(current_sense_gain[p*16 +: 16]);
			assign corr = $signed({57'd0, pg_tccfg[p*8 +: 7]}) *
				dt_q8;
			// truncating division: tiny corrections fall to zero
			assign res_q8 = gain_q8 +
				(gain_q8 * corr) / $signed(`TGR_TC_DIV);

			// per-page results collected for one result register
			assign rep_all[p*16 +: 16] = rep_q8[15:0];
			assign res_all[p*32 +: 32] = res_q8[31:0];
		end
	endgenerate

	// measurement results, registered for all pages at once
	always @(posedge mclk)
	begin
		if (reset)
		begin
			ext_temp_report <= {NUM_PAGES*16{1'b0}};
			sense_resistance <= {NUM_PAGES*32{1'b0}};
		end
		else
		begin
			ext_temp_report <= rep_all;
			sense_resistance <= res_all;
		end
	end

	// readback mux of the addressed page
	always @*
	begin
		next_rd = 16'h0000;
		if (page_ok)
		begin
			case (cmd_code)
			`TGR_CMD_SCALE: next_rd = pg_scale[cmd_page*16 +: 16];
			`TGR_CMD_OFFSET: next_rd = pg_offset[cmd_page*16 +: 16];
			`TGR_CMD_TCCFG: next_rd = {8'h00, pg_tccfg[cmd_page*8 +: 8]};
			`TGR_CMD_GAPT: next_rd = pg_gapt[cmd_page*16 +: 16];
			`TGR_CMD_GAPC: next_rd = pg_gapc[cmd_page*16 +: 16];
			default: next_rd = 16'h0000;
			endcase
		end
	end

	// one-cycle answer to every command
	always @(posedge mclk)
	begin
		if (reset)
		begin
			rsp_valid <= 1'b0;
			rsp_data <= 16'h0000;
			rsp_error <= 1'b0;
		end
		else
		begin
			rsp_valid <= cmd_valid;
			rsp_data <= rd_take ? next_rd : 16'h0000;
			rsp_error <= cmd_valid && refuse;
		end
	end

endmodule // tgr_regs

// ### sim/tgr_regs_properties.sv
module tgr_regs_properties #(
	parameter NUM_PAGES = 2,
	parameter PAGE_W = 1
) (
	input wire mclk,
	input wire reset,
	input wire cmd_valid,
	input wire cmd_write,
	input wire [7:0] cmd_code,
	input wire write_protect,
	input wire rsp_valid,
	input wire [15:0] rsp_data,
	input wire rsp_error,
	input wire [NUM_PAGES*8-1:0] gap_hl_ns,
	input wire [NUM_PAGES*8-1:0] gap_lh_ns,
	input wire [NUM_PAGES-1:0] gap_overlap_hl,
	input wire [NUM_PAGES-1:0] gap_overlap_lh
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	// mapped command codes
	wire known = cmd_code inside {8'hD9, 8'hDA, 8'hDC, 8'hDD, 8'hDE};
	// command classes
	sequence s_write;
		cmd_valid && cmd_write;
	endsequence
	sequence s_bad;
		cmd_valid && (!known || cmd_write && write_protect);
	endsequence
	sequence s_good;
		cmd_valid && known && !(cmd_write && write_protect);
	endsequence
	property p_answer;
		cmd_valid |=> rsp_valid;
	endproperty
	property p_quiet;
		!cmd_valid |=> !rsp_valid;
	endproperty
	property p_wr_zero;
		s_write |=> rsp_data == 16'h0000;
	endproperty
	property p_refuse;
		s_bad |=> rsp_error && rsp_data == 16'h0000;
	endproperty
	property p_accept;
		s_good |=> !rsp_error;
	endproperty
	property p_sign;
		gap_overlap_hl[0] == gap_hl_ns[7] && gap_overlap_lh[0] == gap_lh_ns[7];
	endproperty
	property p_range;
		$signed(gap_hl_ns[7:0]) >= -15 && $signed(gap_hl_ns[7:0]) <= 60;
	endproperty
	property p_rst;
		$fell(reset) |-> gap_hl_ns[7:0] == 8'h10 && gap_lh_ns[7:0] == 8'h10;
	endproperty
	a_answer: assert property (p_answer)
		else $error("no answer after a command");
	a_quiet: assert property (p_quiet)
		else $error("answer without a command");
	a_wr_zero: assert property (p_wr_zero)
		else $error("write answered with data");
	a_refuse: assert property (p_refuse)
		else $error("bad command not refused");
	a_accept: assert property (p_accept)
		else $error("good command refused");
	a_sign: assert property (p_sign)
		else $error("overlap flag differs from gap sign");
	a_range: assert property (p_range)
		else $error("gap outside supported range");
	a_rst: assert property (p_rst)
		else $error("gap not at default after reset");
endmodule // tgr_regs_properties

// ### sim/tgr_regs_tb.sv
module tgr_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, reset, cmd_valid, cmd_write, cmd_page, write_protect;
	logic rsp_valid, rsp_error;
	logic [7:0] cmd_code;
	logic [15:0] cmd_wdata, rsp_data, int_temp_raw;
	logic [15:0] adaptive_gap_hl, adaptive_gap_lh, switch_gap_upper_limit;
	logic [15:0] gap_hl_ns, gap_lh_ns;
	logic [31:0] ext_temp_raw, current_sense_gain, ext_temp_report;
	logic [63:0] sense_resistance;
	logic [1:0] gap_overlap_hl, gap_overlap_lh;
	logic [15:0] mdl [0:1][0:255];
	logic [7:0] codes [5] = '{8'hD9, 8'hDA, 8'hDC, 8'hDD, 8'hDE};
	integer vals [5] = '{-20, 0, 30, 70, 9};
	integer fail_count = 0;
	integer tests_run = 0;
	integer i, k, ul, t;
	tgr_regs #(.NUM_PAGES(2), .PAGE_W(1)) dut (.mclk(mclk), .reset(reset),
		.cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_page(cmd_page),
		.cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
		.write_protect(write_protect), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .rsp_error(rsp_error),
		.ext_temp_raw(ext_temp_raw), .int_temp_raw(int_temp_raw),
		.current_sense_gain(current_sense_gain),
		.adaptive_gap_hl(adaptive_gap_hl), .adaptive_gap_lh(adaptive_gap_lh),
		.switch_gap_upper_limit(switch_gap_upper_limit),
		.ext_temp_report(ext_temp_report),
		.sense_resistance(sense_resistance), .gap_hl_ns(gap_hl_ns),
		.gap_lh_ns(gap_lh_ns), .gap_overlap_hl(gap_overlap_hl),
		.gap_overlap_lh(gap_overlap_lh));
	// clock
	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		$display("tests_run %0d fail_count %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// gap limited by minimum field and upper limit
	function automatic logic [7:0] clamp(input integer v, input integer mn);
		integer lo, hi;
		lo = (2 * mn > -15) ? 2 * mn : -15;
		hi = (ul < 60) ? ul : 60;
		return 8'((v < lo) ? lo : (v > hi) ? hi : v);
	endfunction
	// one command, answer checked one cycle later against the model
	task automatic cmd(input logic w, input logic p, input logic [7:0] c,
		input logic [15:0] d);
		logic ok, err;
		logic [15:0] e;
		ok = c inside {8'hD9, 8'hDA, 8'hDC, 8'hDD, 8'hDE};
		e = (w || !ok) ? 16'h0000 : mdl[p][c];
		err = !ok || (w && write_protect);
		@(negedge mclk);
		{cmd_valid, cmd_write, cmd_page, cmd_code, cmd_wdata} = {1'b1, w, p, c, d};
		@(negedge mclk);
		cmd_valid = 1'b0;
		check({rsp_valid, rsp_error, rsp_data}, {1'b1, err, e});
		if (w && !err)
			mdl[p][c] = (c == 8'hDC) ? {8'h00, d[7:0]} : d;
	endtask
	// model registers after any reset
	task automatic mdl_reset;
		for (int j = 0; j < 2; j++)
		begin
			{mdl[j][8'hD9], mdl[j][8'hDA]} = {16'hBA00, 16'h0000};
			{mdl[j][8'hDC], mdl[j][8'hDD]} = {16'h0027, 16'h1010};
			mdl[j][8'hDE] = 16'h0808;
		end
	endtask
	// gap settle and compare on page 0
	task automatic gap_chk(input integer v, input integer mn);
		adaptive_gap_hl[7:0] = v[7:0];
		adaptive_gap_lh[7:0] = v[7:0];
		repeat (2) @(negedge mclk);
		check({gap_hl_ns[7:0], gap_lh_ns[7:0]}, {2{clamp(v, mn)}});
	endtask
	initial
	begin
		#(25 * 3000);
		fail_count++;
		$display("Error at %0t: watchdog expired", $time);
		complete_run;
	end
	initial
	begin
		{cmd_valid, cmd_write, cmd_page, cmd_code, cmd_wdata} = '0;
		{reset, write_protect, ext_temp_raw} = {1'b1, 1'b0, 32'h0};
		{int_temp_raw, current_sense_gain} = {16'h1900, {2{16'hBA00}}};
		{adaptive_gap_hl, adaptive_gap_lh} = {4{8'h14}};
		void'($urandom(33));
		ul = 30 + $urandom % 40;
		switch_gap_upper_limit = {2{ul[7:0]}};
		mdl_reset;
		repeat (4) @(negedge mclk);
		reset = 1'b0;
		// default values on both pages
		for (k = 0; k < 10; k++)
			cmd(1'b0, k[0], codes[k / 2], 16'h0000);
		$display("test defaults done");
		// random traffic with protection and unmapped codes
		for (k = 0; k < 60; k++)
		begin
			write_protect = ($urandom % 4 == 0);
			i = $urandom % 7;
			cmd($urandom % 2, $urandom % 2, (i > 4) ? 8'hDB + 8'h04 * (i - 5)
				: codes[i], $urandom);
		end
		write_protect = 1'b0;
		for (k = 0; k < 10; k++)
			cmd(1'b0, k[0], codes[k / 2], 16'h0000);
		$display("test random access done");
		// adaptive gaps clamped by minimum and upper limit
		cmd(1'b1, 1'b0, 8'hDE, 16'h0404);
		for (k = 0; k < 5; k++)
			gap_chk(vals[k], 4);
		// freeze high-to-low, low-to-high stays adaptive
		gap_chk(24, 4);
		cmd(1'b1, 1'b0, 8'hDE, 16'h8404);
		adaptive_gap_hl[7:0] = 8'h0C;
		adaptive_gap_lh[7:0] = 8'h0C;
		repeat (2) @(negedge mclk);
		check({gap_hl_ns[7:0], gap_lh_ns[7:0]}, {clamp(24, 4), 8'h0C});
		// written gaps apply while frozen, still limited
		cmd(1'b1, 1'b0, 8'hDE, 16'h8000);
		for (k = 0; k < 3; k++)
		begin
			i = $signed({vals[k][7:0]});
			cmd(1'b1, 1'b0, 8'hDD, {vals[k][7:0], 8'h05});
			@(negedge mclk);
			check({gap_overlap_hl[0], gap_hl_ns[7:0]}, {1'b0, clamp(i, 0)});
		end
		// page 1 keeps its own gaps, with no overlap on either page
		cmd(1'b1, 1'b1, 8'hDE, 16'h0404);
		@(negedge mclk);
		check({gap_overlap_hl, gap_overlap_lh, gap_hl_ns[15:8],
			gap_lh_ns[15:8]}, {4'h0, {2{clamp(20, 4)}}});
		$display("test gaps done");
		// report equals raw over unity scale plus one degree
		cmd(1'b1, 1'b0, 8'hD9, 16'hBA00);
		cmd(1'b1, 1'b0, 8'hDA, 16'h0001);
		ext_temp_raw[15:0] = $urandom;
		repeat (2) @(negedge mclk);
		check(ext_temp_report[15:0],
			16'(ext_temp_raw[15:0] + 16'h0100));
		$display("test temperature report done");
		// sense resistance from the internal sensor, then from the pin
		for (k = 0; k < 2; k++)
		begin
			i = $urandom % 64;
			// correction byte written each pass: bit 7 picks the source, bits 6:0 the coefficient
			cmd(1'b1, 1'b0, 8'hDC, {8'h00, k[0], i[6:0]});
			{int_temp_raw, ext_temp_raw[15:0]} = $urandom;
			if (k)
				t = $signed(ext_temp_raw[15:0]) + 256;
			else
				t = $signed(int_temp_raw);
			repeat (2) @(negedge mclk);
			check(sense_resistance[31:0],
				256 + (256 * i * (t - 25 * 256)) / (10000 * 256));
		end
		$display("test sense resistance done");
		// reset in mid-run brings every default back
		reset = 1'b1;
		repeat (2) @(negedge mclk);
		check({gap_hl_ns, gap_lh_ns}, 32'h10101010);
		check(ext_temp_report, 32'h00000000);
		check(sense_resistance[31:0], 32'h00000000);
		reset = 1'b0;
		mdl_reset;
		for (k = 0; k < 10; k++)
			cmd(1'b0, k[0], codes[k / 2], 16'h0000);
		$display("test mid-run reset done");
		complete_run;
	end
endmodule // tgr_regs_tb

bind tgr_regs tgr_regs_properties #(.NUM_PAGES(NUM_PAGES), .PAGE_W(PAGE_W))
	u_props (.mclk(mclk), .reset(reset), .cmd_valid(cmd_valid),
	.cmd_write(cmd_write), .cmd_code(cmd_code), .write_protect(write_protect),
	.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_error(rsp_error),
	.gap_hl_ns(gap_hl_ns), .gap_lh_ns(gap_lh_ns),
	.gap_overlap_hl(gap_overlap_hl), .gap_overlap_lh(gap_overlap_lh));
